//--- src/emibc_bus_ctrl.sv
`timescale 1ns/10ps
module emibc_bus_ctrl
    import emibc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWrData,
    output logic [7:0]      sfrRdData_r,
    // cpu move request and answer
    input  wire logic       reqValid,
    input  emibc_req_t      reqIn,
    output logic            reqReady_r,
    output logic            respValid_r,
    output logic [7:0]      respData_r,
    // on-chip xram and usb fifo access
    output logic            localReq_r,
    output logic            localUsb_r,
    output logic            localWrite_r,
    output logic [15:0]     localAddr_r,
    output logic [7:0]      localWrData_r,
    input  wire logic [7:0] localRdData,
    // external memory pins
    input  wire logic [7:0] adIn,
    input  wire logic [7:0] dataIn,
    output emibc_pins_t     pins_r
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ALE_HI = 3'b001,
        ST_ALE_LO = 3'b011,
        ST_SETUP  = 3'b010,
        ST_STROBE = 3'b110,
        ST_HOLD   = 3'b111,
        ST_DONE   = 3'b101,
        ST_LOCAL  = 3'b100
    } emibc_state_t;

    emibc_cfg_t   cfg;
    logic [7:0]   page;
    emibc_route_t routeIn;
    emibc_state_t state_r;
    emibc_state_t state_nxt;
    emibc_req_t   req_r;
    emibc_route_t route_r;
    emibc_req_t   curReq;
    emibc_route_t curRoute;
    logic         mux_r;
    logic [2:0]   aleCnt_r;
    logic [2:0]   aleLen;
    emibc_pins_t  pins_nxt;
    logic         accept;

    emibc_sfr_regs u_regs (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .sfrAddr     (sfrAddr),
        .sfrWrEn     (sfrWrEn),
        .sfrRdEn     (sfrRdEn),
        .sfrWrData   (sfrWrData),
        .sfrRdData_r (sfrRdData_r),
        .cfg         (cfg),
        .page_r      (page)
    );

    emibc_addr_route u_route (
        .cfg   (cfg),
        .page  (page),
        .req   (reqIn),
        .route (routeIn)
    );

    assign accept = reqValid && state_r == ST_IDLE;
    assign aleLen = ALE_BASE_CYC + {1'b0, cfg.aleWidth};

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (reqValid) begin
                    if (!routeIn.ext) begin
                        state_nxt = ST_LOCAL;
                    end else if (!cfg.nonMux) begin
                        state_nxt = ST_ALE_HI;
                    end else begin
                        state_nxt = ST_SETUP;
                    end
                end
            end
            ST_ALE_HI: begin
                if (aleCnt_r == ALE_BASE_CYC) begin
                    state_nxt = ST_ALE_LO;
                end
            end
            ST_ALE_LO: begin
                if (aleCnt_r == ALE_BASE_CYC) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP:  state_nxt = ST_STROBE;
            ST_STROBE: state_nxt = ST_HOLD;
            ST_HOLD:   state_nxt = ST_DONE;
            ST_LOCAL:  state_nxt = ST_DONE;
            ST_DONE:   state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // request and mode are frozen for the whole access, so a config write mid-access can change only the width of the ale low phase
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            req_r   <= '0;
            route_r <= '0;
            mux_r   <= 1'b0;
        end else if (accept) begin
            req_r   <= reqIn;
            route_r <= routeIn;
            mux_r   <= !cfg.nonMux;
        end
    end

    // latch enable phase counter, width sampled at the start of each phase
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            aleCnt_r <= ALE_BASE_CYC;
        end else if (state_nxt != state_r) begin
            aleCnt_r <= aleLen;
        end else if (aleCnt_r != ALE_BASE_CYC) begin
            aleCnt_r <= aleCnt_r - ALE_BASE_CYC;
        end
    end

    assign curReq   = (state_r == ST_IDLE) ? reqIn : req_r;
    assign curRoute = (state_r == ST_IDLE) ? routeIn : route_r;

    // pin values for the coming cycle; registered so the pins never glitch
    always_comb begin
        pins_nxt           = '0;
        pins_nxt.adOeN     = 1'b1;
        pins_nxt.addrLoOeN = 1'b1;
        pins_nxt.addrHiOeN = 1'b1;
        pins_nxt.dataOeN   = 1'b1;
        pins_nxt.rdN       = 1'b1;
        pins_nxt.wrN       = 1'b1;
        case (state_nxt)
            ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD: begin
                pins_nxt.addrHiOut = curRoute.addr[15:8];
                pins_nxt.addrHiOeN = !curRoute.driveHigh;
                if (state_nxt == ST_ALE_HI || state_nxt == ST_ALE_LO) begin
                    pins_nxt.adOut = curRoute.addr[7:0];
                    pins_nxt.adOeN = 1'b0;
                    pins_nxt.ale   = (state_nxt == ST_ALE_HI);
                end else if ((state_r == ST_IDLE) ? !cfg.nonMux : mux_r) begin
                    pins_nxt.adOut = curReq.wdata;
                    pins_nxt.adOeN = !curReq.write;
                end else begin
                    pins_nxt.addrLoOut = curRoute.addr[7:0];
                    pins_nxt.addrLoOeN = 1'b0;
                    pins_nxt.dataOut   = curReq.wdata;
                    pins_nxt.dataOeN   = !curReq.write;
                end
                if (state_nxt == ST_STROBE) begin
                    pins_nxt.rdN = curReq.write;
                    pins_nxt.wrN = !curReq.write;
                end
            end
            default: begin
                pins_nxt.adOeN = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pins_r <= '{adOut: 8'h00, adOeN: 1'b1, addrLoOut: 8'h00, addrLoOeN: 1'b1, addrHiOut: 8'h00,
                        addrHiOeN: 1'b1, dataOut: 8'h00, dataOeN: 1'b1, ale: 1'b0, rdN: 1'b1, wrN: 1'b1};
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // on-chip or usb fifo access is a one-cycle request, data sampled a cycle later
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            localReq_r    <= 1'b0;
            localUsb_r    <= 1'b0;
            localWrite_r  <= 1'b0;
            localAddr_r   <= 16'h0000;
            localWrData_r <= 8'h00;
        end else begin
            localReq_r <= accept && !routeIn.ext;
            if (accept && !routeIn.ext) begin
                localUsb_r    <= routeIn.usb;
                localWrite_r  <= reqIn.write;
                localAddr_r   <= routeIn.addr;
                localWrData_r <= reqIn.wdata;
            end
        end
    end

    // answer path
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            respValid_r <= 1'b0;
            respData_r  <= 8'h00;
            reqReady_r  <= 1'b0;
        end else begin
            respValid_r <= state_nxt == ST_DONE;
            reqReady_r  <= state_nxt == ST_IDLE;
            if (state_r == ST_STROBE && !req_r.write) begin
                respData_r <= mux_r ? adIn : dataIn;
            end else if (state_r == ST_LOCAL && !req_r.write) begin
                respData_r <= localRdData;
            end
        end
    end

    // assertion helpers
    logic [2:0] aleHighCnt;
    logic [2:0] aleWant;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            aleHighCnt <= 3'h0;
            aleWant    <= 3'h0;
        end else begin
            aleHighCnt <= pins_r.ale ? aleHighCnt + ALE_BASE_CYC : 3'h0;
            if (accept) begin
                aleWant <= aleLen;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_ale_fall;
        $fell(pins_r.ale);
    endsequence

    sequence s_phase_two;
        !pins_r.ale [*1] ##[1:5] (!pins_r.rdN || !pins_r.wrN);
    endsequence

    a_mux_select: assert property (accept && routeIn.ext |=> (state_r == ST_ALE_HI) == !cfg.nonMux)
        else $error("bus mode does not follow the multiplex select");
    a_ale_phase_addr: assert property (pins_r.ale |-> !pins_r.adOeN && pins_r.adOut == route_r.addr[7:0])
        else $error("low address missing while latch enable high");
    a_ale_mux_only: assert property (pins_r.ale |-> mux_r)
        else $error("latch enable driven in separate mode");
    a_ale_fall_phase: assert property (s_ale_fall |-> s_phase_two)
        else $error("no strobe after latch enable fell");
    a_ale_width: assert property ($fell(pins_r.ale) |-> aleHighCnt == aleWant)
        else $error("latch enable high width wrong");
    a_strobe_shared: assert property (!pins_r.wrN && mux_r |-> !pins_r.adOeN && pins_r.adOut == req_r.wdata)
        else $error("shared lines do not carry write data at strobe");
    a_sep_pins: assert property ((!pins_r.rdN || !pins_r.wrN) && !mux_r |-> pins_r.adOeN && !pins_r.ale
                                 && !pins_r.addrLoOeN)
        else $error("separate mode uses the shared lines");
    a_usb_hides: assert property (accept && emibc_in_usb(routeIn.addr, cfg.usbMap) |=> localReq_r && localUsb_r)
        else $error("usb window access went to normal memory");
    a_page_high: assert property (accept && reqIn.byteMode |-> routeIn.addr[15:8] == page)
        else $error("8-bit move high byte not from page");
    a_mode_internal: assert property (accept && cfg.memMode == MODE_INT |=> localReq_r)
        else $error("internal-only mode went off chip");
    a_mode_external: assert property (accept && cfg.memMode == MODE_EXT && !routeIn.usb |=> !localReq_r)
        else $error("external-only mode stayed on chip");
endmodule : emibc_bus_ctrl

//--- src/emibc_pkg.sv
package emibc_pkg;
    // register map
    localparam logic [7:0]  CFG_ADDR     = 8'h85;
    localparam logic [7:0]  PAGE_ADDR    = 8'haa;
    localparam logic [7:0]  CFG_RESET    = 8'h03;
    localparam logic [7:0]  PAGE_RESET   = 8'h00;
    // bits 7 and 5 are unused
    localparam logic [7:0]  CFG_WR_MASK  = 8'h5f;
    localparam int          CFG_USB_BIT  = 6;
    localparam int          CFG_MUX_BIT  = 4;
    localparam int          CFG_MODE_LSB = 2;
    localparam int          CFG_ALE_LSB  = 0;
    // usb fifo window and on-chip xram size
    localparam logic [15:0] USB_LO       = 16'h0400;
    localparam logic [15:0] USB_HI       = 16'h07ff;
    localparam logic [16:0] XRAM_SIZE    = 17'h01000;
    // ale phase width is field value plus this, in system clocks
    localparam logic [2:0]  ALE_BASE_CYC = 3'h1;

    typedef enum logic [1:0] {
        MODE_INT   = 2'h0,
        MODE_SPLIT = 2'h1,
        MODE_BANK  = 2'h2,
        MODE_EXT   = 2'h3
    } emibc_mode_t;

    typedef struct packed {
        logic        usbMap;
        logic        nonMux;
        emibc_mode_t memMode;
        logic [1:0]  aleWidth;
    } emibc_cfg_t;

    typedef struct packed {
        logic        write;
        logic        byteMode;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emibc_req_t;

    typedef struct packed {
        logic        ext;
        logic        usb;
        logic        driveHigh;
        logic [15:0] addr;
    } emibc_route_t;

    typedef struct packed {
        logic [7:0] adOut;
        logic       adOeN;
        logic [7:0] addrLoOut;
        logic       addrLoOeN;
        logic [7:0] addrHiOut;
        logic       addrHiOeN;
        logic [7:0] dataOut;
        logic       dataOeN;
        logic       ale;
        logic       rdN;
        logic       wrN;
    } emibc_pins_t;

    function automatic logic emibc_in_usb(input logic [15:0] a, input logic en);
        emibc_in_usb = en && (a >= USB_LO) && (a <= USB_HI);
    endfunction : emibc_in_usb
endpackage : emibc_pkg

//--- src/emibc_sfr_regs.sv
`timescale 1ns/10ps
module emibc_sfr_regs
    import emibc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWrData,
    output logic [7:0]      sfrRdData_r,
    // decoded configuration
    output emibc_cfg_t      cfg,
    output logic [7:0]      page_r
);
    logic [7:0] cfgRaw_r;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfgRaw_r <= CFG_RESET;
        end else if (sfrWrEn && sfrAddr == CFG_ADDR) begin
            cfgRaw_r <= sfrWrData & CFG_WR_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            page_r <= PAGE_RESET;
        end else if (sfrWrEn && sfrAddr == PAGE_ADDR) begin
            page_r <= sfrWrData;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sfrRdData_r <= 8'h00;
        end else if (sfrRdEn) begin
            sfrRdData_r <= (sfrAddr == CFG_ADDR) ? cfgRaw_r : (sfrAddr == PAGE_ADDR) ? page_r : 8'h00;
        end
    end

    assign cfg.usbMap   = cfgRaw_r[CFG_USB_BIT];
    assign cfg.nonMux   = cfgRaw_r[CFG_MUX_BIT];
    assign cfg.memMode  = emibc_mode_t'(cfgRaw_r[CFG_MODE_LSB +: 2]);
    assign cfg.aleWidth = cfgRaw_r[CFG_ALE_LSB +: 2];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_cfg_unused_zero: assert property (sfrRdEn && sfrAddr == CFG_ADDR |=> sfrRdData_r[7] == 1'b0 && sfrRdData_r[5] == 1'b0)
        else $error("unused config bits read non-zero");
endmodule : emibc_sfr_regs

//--- src/emibc_addr_route.sv
`timescale 1ns/10ps
module emibc_addr_route
    import emibc_pkg::*;
(
    // configuration
    input  emibc_cfg_t   cfg,
    input  wire logic [7:0] page,
    // request
    input  emibc_req_t   req,
    // decision
    output emibc_route_t route
);
    logic [15:0] eff;
    logic        usbHit;
    logic        extHit;
    logic        noHigh;

    always_comb begin
        eff    = req.byteMode ? {page, req.addr[7:0]} : req.addr;
        // software keeps the usb clock at twice the system clock; no check here
        usbHit = emibc_in_usb(eff, cfg.usbMap);
        case (cfg.memMode)
            MODE_INT:   extHit = 1'b0;
            MODE_SPLIT: extHit = {1'b0, eff} >= XRAM_SIZE;
            MODE_BANK:  extHit = {1'b0, eff} >= XRAM_SIZE;
            MODE_EXT:   extHit = 1'b1;
            default:    extHit = 1'b0;
        endcase
        // 8-bit moves leave the upper pins to the port latches except with bank select
        noHigh = req.byteMode && (cfg.memMode == MODE_SPLIT || cfg.memMode == MODE_EXT);
        route.usb       = usbHit;
        route.ext       = extHit && !usbHit;
        route.driveHigh = extHit && !usbHit && !noHigh;
        route.addr      = eff;
    end
endmodule : emibc_addr_route

//--- verif/emibc_ext_mem_model.sv
`timescale 1ns/10ps
module emibc_ext_mem_model
    import emibc_pkg::*;
(
    // clock
    input  wire logic   ref_clk,
    // pins driven by the interface
    input  emibc_pins_t pins,
    // wire levels seen back by the interface
    output logic [7:0]  adIn,
    output logic [7:0]  dataIn
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  latchQ;
    logic [7:0]  adPrev   = 8'h3c;
    logic [7:0]  dataPrev = 8'hc3;
    logic [15:0] memAddr;

    // transparent while enable is high, frozen once it falls
    always_latch begin
        if (pins.ale) begin
            latchQ = pins.adOut;
        end
    end

    // undriven upper lines sit at the parked port level
    assign memAddr = {pins.addrHiOeN ? 8'hff : pins.addrHiOut, pins.addrLoOeN ? latchQ : pins.addrLoOut};

    // released lines toggle so a stale value is never mistaken for data
    always @(ref_clk or pins or memAddr or adPrev or dataPrev) begin
        adIn   = pins.adOeN ? ~adPrev : pins.adOut;
        dataIn = pins.dataOeN ? ~dataPrev : pins.dataOut;
        if (!pins.rdN && pins.adOeN && pins.addrLoOeN) begin
            adIn = mem[memAddr];
        end
        if (!pins.rdN && pins.dataOeN && !pins.addrLoOeN) begin
            dataIn = mem[memAddr];
        end
    end

    always_ff @(posedge ref_clk) begin
        adPrev   <= adIn;
        dataPrev <= dataIn;
        if (!pins.wrN) begin
            mem[memAddr] <= pins.addrLoOeN ? pins.adOut : pins.dataOut;
        end
    end
endmodule : emibc_ext_mem_model

//--- verif/tb.sv
`timescale 1ns/10ps
module tb
    import emibc_pkg::*;
;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic [7:0]  sfrAddr   = 8'h00;
    logic        sfrWrEn   = 1'b0;
    logic        sfrRdEn   = 1'b0;
    logic [7:0]  sfrWrData = 8'h00;
    logic        reqValid  = 1'b0;
    emibc_req_t  reqIn     = '0;
    logic [7:0]  sfrRdData_r, respData_r, localWrData_r, localRdData, adIn, dataIn, v, rdData;
    logic        reqReady_r, respValid_r, localReq_r, localUsb_r, localWrite_r, sawLocal, sawUsb;
    logic [15:0] localAddr_r;
    emibc_pins_t pins_r;
    int          bad_count, samples_checked, cyc, aleCyc;
    logic [7:0]  cfgT [11] = '{8'h13, 8'h17, 8'h17, 8'h1b, 8'h1b, 8'h1f, 8'h5f, 8'h5f, 8'h5f, 8'h1f, 8'h53};
    logic [15:0] adrT [11] = '{16'h1234, 16'h0800, 16'h3000, 16'h0fff, 16'h1000, 16'h0000, 16'h0400,
                               16'h07ff, 16'h0800, 16'h0400, 16'h03ff};
    logic [1:0]  expT [11] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h2};

    always #2 ref_clk = ~ref_clk;
    // on-chip memory stand-in returns a pattern of its address
    assign localRdData = localAddr_r[7:0] ^ 8'ha5;

    emibc_bus_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData_r(sfrRdData_r), .reqValid(reqValid),
        .reqIn(reqIn), .reqReady_r(reqReady_r), .respValid_r(respValid_r), .respData_r(respData_r),
        .localReq_r(localReq_r), .localUsb_r(localUsb_r), .localWrite_r(localWrite_r),
        .localAddr_r(localAddr_r), .localWrData_r(localWrData_r), .localRdData(localRdData),
        .adIn(adIn), .dataIn(dataIn), .pins_r(pins_r));
    emibc_ext_mem_model mem_u (.ref_clk(ref_clk), .pins(pins_r), .adIn(adIn), .dataIn(dataIn));

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chkI(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : chkI

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfrAddr   = a;
        sfrWrData = d;
        sfrWrEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        sfrWrEn = 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        sfrRdEn = 1'b0;
        d = sfrRdData_r;
    endtask : sfr_rd

    // one move; latency counted in edges from the take edge to the answer
    task automatic acc(input logic w, input logic bm, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        #1;
        reqIn    = '{write: w, byteMode: bm, addr: a, wdata: d};
        reqValid = 1'b1;
        n = 0;
        while (reqReady_r !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        #1;
        reqValid = 1'b0;
        cyc      = 0;
        aleCyc   = 0;
        sawLocal = 1'b0;
        sawUsb   = 1'b0;
        // pins and local strobe already show the take edge here, so look before waiting
        while (respValid_r !== 1'b1 && cyc < 50) begin
            if (pins_r.ale === 1'b1) aleCyc++;
            if (localReq_r === 1'b1) begin
                sawLocal = 1'b1;
                sawUsb   = localUsb_r;
            end
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        rdData = respData_r;
        // a move never taken or never answered is a failure in itself
        if (n >= 50 || cyc >= 50) bad_count++;
    endtask : acc

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // the sequence needs well under a thousand cycles, so this is ample
    initial begin
        #80000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        sfr_rd(CFG_ADDR, v);
        chk8("config reset", CFG_RESET, v);
        sfr_rd(PAGE_ADDR, v);
        chk8("page reset", PAGE_RESET, v);
        sfr_wr(CFG_ADDR, 8'hff);
        sfr_rd(CFG_ADDR, v);
        chk8("config unused bits", 8'h5f, v);
        sfr_wr(8'h10, 8'h77);
        sfr_rd(8'h10, v);
        chk8("unmapped read", 8'h00, v);
        for (int i = 0; i < 11; i++) begin
            sfr_wr(CFG_ADDR, cfgT[i]);
            acc(1'b0, 1'b0, adrT[i], 8'h00);
            chk8("local pick", {7'h0, expT[i][1]}, {7'h0, sawLocal});
            chk8("usb pick", {7'h0, expT[i][0]}, {7'h0, sawUsb});
            // cyc counts edges after the take edge; the whole move spans two cycles more
            chkI("route latency", expT[i][1] ? 3 : 5, cyc + 2);
            if (expT[i][1]) chk8("local data", adrT[i][7:0] ^ 8'ha5, rdData);
        end
        for (int f = 0; f < 4; f++) begin
            sfr_wr(CFG_ADDR, 8'h0c | 8'(f));
            acc(1'b1, 1'b0, 16'h2000 + 16'(f), 8'h5a + 8'(f));
            chkI("mux cycles", 7 + 2 * f, cyc + 2);
            chkI("latch enable high", f + 1, aleCyc);
            acc(1'b0, 1'b0, 16'h2000 + 16'(f), 8'h00);
            chk8("mux data", 8'h5a + 8'(f), rdData);
        end
        sfr_wr(CFG_ADDR, 8'h1c);
        acc(1'b1, 1'b0, 16'h3001, 8'h99);
        chkI("separate cycles", 5, cyc + 2);
        chkI("separate latch enable", 0, aleCyc);
        acc(1'b0, 1'b0, 16'h3001, 8'h00);
        chk8("separate data", 8'h99, rdData);
        sfr_wr(PAGE_ADDR, 8'h12);
        sfr_rd(PAGE_ADDR, v);
        chk8("page readback", 8'h12, v);
        sfr_wr(CFG_ADDR, 8'h1b);
        acc(1'b1, 1'b1, 16'h0034, 8'hc3);
        acc(1'b0, 1'b0, 16'h1234, 8'h00);
        chk8("paged write", 8'hc3, rdData);
        sfr_wr(CFG_ADDR, 8'h17);
        acc(1'b1, 1'b1, 16'h0056, 8'h3e);
        acc(1'b0, 1'b0, 16'hff56, 8'h00);
        chk8("upper lines parked", 8'h3e, rdData);
        sfr_wr(CFG_ADDR, 8'h13);
        acc(1'b1, 1'b1, 16'h0077, 8'h4e);
        chk8("local write flag", 8'h01, {7'h0, localWrite_r});
        chk8("local write data", 8'h4e, localWrData_r);
        chk8("local page byte", 8'h12, localAddr_r[15:8]);
        final_report();
    end
endmodule : tb
